/* rtl/gtc_pkg.sv */
// Constants shared by the gated 16-bit timer/counter modules
package gtc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CNT_LO = 5'h00;
  localparam logic [4:0] OFS_CNT_HI = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_CMP_CTRL = 5'h0C;
  localparam logic [4:0] OFS_FLAG = 5'h10;
  localparam logic [4:0] OFS_ENABLE = 5'h14;
  localparam logic [4:0] OFS_IRQ_CTRL = 5'h18;
  localparam logic [4:0] OFS_PORT = 5'h1C;
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_ON = 0;
  localparam int CTRL_CS = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_OSC = 3;
  localparam int CTRL_PS_LO = 4;
  localparam int CTRL_PS_HI = 5;
  localparam int CTRL_GE = 6;
  localparam int CTRL_GPOL = 7;
  localparam int CMP_GSS = 1;
  localparam int FLAG_OVF = 0;
  localparam int IRQ_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int IRQ_GIE = 7;
  localparam int PORT_DIR_LO = 2;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] CMP_CTRL_RST = 2'h0;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam int FOSC_DIV = 4;
  localparam logic [1:0] FOSC_LAST = 2'(FOSC_DIV - 1);
  localparam logic [1:0] PORT_READ_OSC = 2'h0;
  localparam logic [1:0] DIR_READ_OSC = 2'h3;
endpackage : gtc_pkg

/* rtl/gtc_cnt_if.sv */
// Count path signals between the timer core and its helper modules
`timescale 1ns/1ps
`default_nettype none
interface gtc_cnt_if;
  logic src_tick;
  logic pre_clear;
  logic [1:0] ratio;
  logic pre_tick;
  logic pin;
  logic resync;
  logic on;
  logic arm_clear;
  logic rise;
  modport pre (input src_tick, input pre_clear, input ratio, output pre_tick);
  modport det (input pin, input resync, input on, input arm_clear, output rise);
  modport core (output src_tick, output pre_clear, output ratio, output pin,
                output resync, output on, output arm_clear, input pre_tick, input rise);
endinterface : gtc_cnt_if
`default_nettype wire

/* rtl/gtc_prescale.sv */
// Prescale counter dividing count ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none
module gtc_prescale (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Count path
  gtc_cnt_if.pre cif
);
  import gtc_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
  } gtc_pre_s;

  gtc_pre_s s_r;
  gtc_pre_s s_nxt;
  logic [2:0] mask;

  // Ratio code n selects a divide by two to the n
  assign mask = 3'((4'h1 << cif.ratio) - 4'h1); // R6
  assign cif.pre_tick = cif.src_tick & ((s_r.cnt & mask) == mask); // R5

  // Counter is hidden from software; a count write clears it
  always_comb
  begin
    s_nxt = s_r;
    if (cif.pre_clear)
      s_nxt.cnt = 3'h0; // R7
    else if (cif.src_tick)
      s_nxt.cnt = s_r.cnt + 3'h1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  div8_a: assert property (@(posedge mclk) disable iff (!resetn) // R5
    (cif.ratio == 2'h3 && cif.pre_tick) |-> (s_r.cnt == 3'h7))
    else $error("divide by eight ticked early");
endmodule : gtc_prescale
`default_nettype wire

/* rtl/gtc_edge.sv */
// Count input edge detector with falling edge arming
`timescale 1ns/1ps
`default_nettype none
module gtc_edge (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Count path
  gtc_cnt_if.det cif
);
  import gtc_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic armed;
    logic hi_off;
    logic on_d;
  } gtc_edge_s;

  gtc_edge_s s_r;
  gtc_edge_s s_nxt;
  logic smp;
  logic fall;

  // Unsynchronised mode bypasses the two-stage path
  assign smp = cif.resync ? s_r.s2 : cif.pin; // R3
  assign fall = cif.on & s_r.prev & ~smp;
  assign cif.rise = cif.on & s_r.armed & smp & ~s_r.prev; // R3

  // A rising edge counts only once a falling edge re-armed the detector
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = cif.pin;
    s_nxt.s2 = s_r.s1;
    s_nxt.prev = smp;
    s_nxt.on_d = cif.on;
    if (!cif.on && s_r.on_d)
      s_nxt.hi_off = smp;
    if (cif.arm_clear || (cif.on && !s_r.on_d && !smp && s_r.hi_off))
      s_nxt.armed = 1'b0; // R4
    if (fall)
      s_nxt.armed = 1'b1; // R4
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  arm_block_a: assert property (@(posedge mclk) disable iff (!resetn) // R4
    (cif.arm_clear && !fall) |=> !cif.rise)
    else $error("rise counted without a falling edge after arm clear");
endmodule : gtc_edge
`default_nettype wire

/* rtl/gtc_timer.sv */
// Gated 16-bit timer/counter with Avalon-MM register access
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: 16-bit counter, byte writes load directly
// R2: Source select 0 internal/4, 1 external
// R3: External rising edges, synchronised or asynchronous
// R4: Falling edge needed before first count
// R5: Prescaler divides by 1, 2, 4, 8
// R6: Prescale code 00,01,10,11 maps 1,2,4,8
// R7: Prescaler hidden, cleared by count write
// R8: Oscillator enable starts crystal, runs asleep
// R9: Oscillator on: port reads 0, direction 1
// R10: Software waits oscillator start-up before enabling
// R11: Async mode counts asleep, overflow wakes
// R12: Count byte reads always valid
// R13: Software stops timer before async writes
// R14: Gate from pin or comparator, needs enable
// R15: Gate source bit in comparator control
// R16: Gated counting only while timer on
// R17: Polarity bit inverts either gate source
// R18: Polarity 1 counts high, 0 low
// R19: Rollover FFFF to 0000 sets overflow flag
// R20: Interrupt needs three enables; flag sticky
// R21: Software clears count and flag first
// R22: Sleep counts only async; overflow wakes
// R23: Count feeds capture and compare unit
// R24: Special event clears count, no flag
// R25: Count write beats special event clear
// R26: Software uses sync mode with trigger
// R27: Software syncs comparator gate output
// R28: Timer off holds count unchanged
module gtc_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [gtc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Count and gate pins
  input wire logic count_input_pin,
  input wire logic osc_input_pin,
  input wire logic gate_pin,
  input wire logic second_comparator_out,
  // Shared port view
  input wire logic [1:0] port_bits_in,
  input wire logic [1:0] port_dir_in,
  // System state
  input wire logic sleep,
  // Capture/compare unit
  input wire logic capture_event,
  input wire logic [15:0] capture_compare_pair,
  input wire logic special_event,
  output logic [15:0] count_value,
  output logic [15:0] capture_value,
  output logic compare_match,
  // Processor side
  output logic irq,
  output logic wake,
  output logic osc_run
);
  import gtc_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] ctrl;
    logic [1:0] cmp_ctrl;
    logic flag;
    logic ie;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic [1:0] fdiv;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    logic wake;
    logic [15:0] cap;
    logic match;
  } gtc_state_s;

  gtc_state_s s_r;
  gtc_state_s s_nxt;
  gtc_cnt_if cif ();

  logic done;
  logic wr_go;
  logic wr_lo;
  logic wr_hi;
  logic cnt_wr;
  logic timer_on;
  logic ext_src;
  logic async_mode;
  logic gate_raw;
  logic gate_act;
  logic run_ok;
  logic fosc_tick;
  logic inc;
  logic ovf;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // The access completes at the edge where waitrequest is low
  assign done = (avs_read | avs_write) & ~s_r.waitreq;
  assign wr_go = avs_write & done & avs_byteenable[0];
  assign wr_lo = wr_go & (avs_address == OFS_CNT_LO);
  assign wr_hi = wr_go & (avs_address == OFS_CNT_HI);
  assign cnt_wr = wr_lo | wr_hi;

  // ------------------------------------------------------------------
  // Count enable path
  // ------------------------------------------------------------------
  assign timer_on = s_r.ctrl[CTRL_ON];
  assign ext_src = s_r.ctrl[CTRL_CS];
  assign async_mode = ext_src & s_r.ctrl[CTRL_SYNC]; // R11
  // Gate source and polarity; polarity applies after the source mux
  assign gate_raw = s_r.cmp_ctrl[CMP_GSS] ? second_comparator_out : gate_pin; // R14 R15
  assign gate_act = s_r.ctrl[CTRL_GPOL] ? gate_raw : ~gate_raw; // R17 R18
  // Gate enable matters only while the timer runs
  assign run_ok = timer_on & (~s_r.ctrl[CTRL_GE] | gate_act) & (~sleep | async_mode); // R16 R22 R28
  // Instruction clock stops in sleep, so only async counting survives
  assign fosc_tick = (s_r.fdiv == FOSC_LAST) & ~sleep; // R2
  assign inc = cif.pre_tick;
  assign ovf = inc & (s_r.count == CNT_MAX); // R19

  // Helper connections; the crystal replaces the pin when enabled
  assign cif.pin = s_r.ctrl[CTRL_OSC] ? osc_input_pin : count_input_pin; // R8
  assign cif.resync = ~s_r.ctrl[CTRL_SYNC]; // R3
  assign cif.on = timer_on & ext_src;
  assign cif.arm_clear = cnt_wr; // R4
  assign cif.src_tick = run_ok & (ext_src ? cif.rise : fosc_tick); // R2
  assign cif.pre_clear = cnt_wr; // R7
  assign cif.ratio = s_r.ctrl[CTRL_PS_HI:CTRL_PS_LO]; // R6

  gtc_edge u_edge (
    .mclk(mclk),
    .resetn(resetn),
    .cif(cif.det)
  );

  gtc_prescale u_pre (
    .mclk(mclk),
    .resetn(resetn),
    .cif(cif.pre)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.fdiv = s_r.fdiv + 2'h1;
    // Two-edge handshake: raise ack, then drop it after completion
    s_nxt.waitreq = 1'b1;
    if ((avs_read || avs_write) && s_r.waitreq)
    begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata = '0;
      case (avs_address)
        OFS_CNT_LO: s_nxt.rdata[7:0] = s_r.count[7:0]; // R12
        OFS_CNT_HI: s_nxt.rdata[7:0] = s_r.count[15:8]; // R12
        OFS_CTRL: s_nxt.rdata[7:0] = s_r.ctrl;
        OFS_CMP_CTRL: s_nxt.rdata[1:0] = s_r.cmp_ctrl;
        OFS_FLAG: s_nxt.rdata[FLAG_OVF] = s_r.flag;
        OFS_ENABLE: s_nxt.rdata[0] = s_r.ie;
        OFS_IRQ_CTRL:
        begin
          s_nxt.rdata[IRQ_PERIPHERAL_IRQ_ENABLE] = s_r.peripheral_irq_enable;
          s_nxt.rdata[IRQ_GIE] = s_r.global_irq_enable;
        end
        OFS_PORT:
        begin
          // Crystal pins are hidden from the port while the oscillator runs
          if (s_r.ctrl[CTRL_OSC])
          begin
            s_nxt.rdata[1:0] = PORT_READ_OSC; // R9
            s_nxt.rdata[PORT_DIR_LO+1:PORT_DIR_LO] = DIR_READ_OSC; // R9
          end
          else
          begin
            s_nxt.rdata[1:0] = port_bits_in;
            s_nxt.rdata[PORT_DIR_LO+1:PORT_DIR_LO] = port_dir_in;
          end
        end
        default: s_nxt.rdata = '0;
      endcase
    end
    // Configuration writes
    if (wr_go)
    begin
      case (avs_address)
        OFS_CTRL: s_nxt.ctrl = avs_writedata[7:0];
        OFS_CMP_CTRL: s_nxt.cmp_ctrl = avs_writedata[1:0];
        OFS_FLAG: s_nxt.flag = avs_writedata[FLAG_OVF];
        OFS_ENABLE: s_nxt.ie = avs_writedata[0];
        OFS_IRQ_CTRL:
        begin
          s_nxt.peripheral_irq_enable = avs_writedata[IRQ_PERIPHERAL_IRQ_ENABLE];
          s_nxt.global_irq_enable = avs_writedata[IRQ_GIE];
        end
        default: s_nxt.ctrl = s_r.ctrl;
      endcase
    end
    // Count: a byte write beats the trigger clear, which beats counting
    if (cnt_wr)
    begin
      if (wr_lo)
        s_nxt.count[7:0] = avs_writedata[7:0]; // R1 R25
      if (wr_hi)
        s_nxt.count[15:8] = avs_writedata[7:0]; // R1 R25
    end
    else if (special_event)
      s_nxt.count = '0; // R24
    else if (inc)
      s_nxt.count = s_r.count + 16'h0001; // R1
    // Overflow sets the sticky flag; a set in the clearing cycle wins
    if (ovf && !cnt_wr && !special_event)
      s_nxt.flag = 1'b1; // R19 R20
    s_nxt.irq = s_r.flag & s_r.ie & s_r.peripheral_irq_enable & s_r.global_irq_enable; // R20
    s_nxt.wake = s_r.flag & s_r.ie & s_r.peripheral_irq_enable & timer_on & sleep; // R11 R22
    // Time base for the capture/compare unit
    if (capture_event)
      s_nxt.cap = s_r.count; // R23
    s_nxt.match = (s_r.count == capture_compare_pair); // R23
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.cmp_ctrl <= CMP_CTRL_RST;
      s_r.waitreq <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // Outputs straight from the state register
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;
  assign count_value = s_r.count;
  assign capture_value = s_r.cap;
  assign compare_match = s_r.match;
  assign irq = s_r.irq;
  assign wake = s_r.wake;
  assign osc_run = s_r.ctrl[CTRL_OSC]; // R8

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence req_wait_s;
    (avs_read || avs_write) && s_r.waitreq;
  endsequence

  sequence ack_then_idle_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  bus_ack_a: assert property (@(posedge mclk) disable iff (!resetn)
    req_wait_s |=> ack_then_idle_s)
    else $error("waitrequest handshake broken");

  ovf_flag_a: assert property (@(posedge mclk) disable iff (!resetn) // R19
    (ovf && !cnt_wr && !special_event) |=> (s_r.flag && s_r.count == 16'h0000))
    else $error("rollover did not set overflow flag");

  sev_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // R24
    (special_event && !cnt_wr) |=> (count_value == 16'h0000 && s_r.flag == $past(s_r.flag)))
    else $error("special event did not clear count cleanly");

  wr_prio_a: assert property (@(posedge mclk) disable iff (!resetn) // R25
    (wr_lo && special_event) |=> (count_value[7:0] == $past(avs_writedata[7:0])))
    else $error("count write lost to special event");

  irq_gate_a: assert property (@(posedge mclk) disable iff (!resetn) // R20
    !(s_r.ie && s_r.peripheral_irq_enable && s_r.global_irq_enable) ##1 1'b1 |-> !irq)
    else $error("interrupt raised without all enables");

  stop_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // R28
    (!timer_on && !cnt_wr && !special_event) |=> $stable(count_value))
    else $error("count moved while timer off");

  gate_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // R16
    (timer_on && s_r.ctrl[CTRL_GE] && !gate_act && !cnt_wr && !special_event)
      |=> $stable(count_value))
    else $error("count moved with gate inactive");

  sleep_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // R22
    (sleep && !async_mode && !cnt_wr && !special_event) |=> $stable(count_value))
    else $error("count moved in sleep outside async mode");

  osc_view_a: assert property (@(posedge mclk) disable iff (!resetn) // R9
    (req_wait_s and (avs_read && avs_address == OFS_PORT && s_r.ctrl[CTRL_OSC]))
      |=> (avs_readdata[3:0] == 4'hC))
    else $error("port view not forced while oscillator on");

  // ------------------------------------------------------------------
  // Count, flag and time base checks
  // ------------------------------------------------------------------
  // Each prescaled tick moves the count by exactly one, wrapping at the top
  inc_step_a: assert property (@(posedge mclk) disable iff (!resetn) // R1
    (inc && !cnt_wr && !special_event)
      |=> (count_value == $past(count_value) + 16'h0001))
    else $error("count did not step by one");

  // Internal source ticks once in every four system clocks
  fosc_rate_a: assert property (@(posedge mclk) disable iff (!resetn) // R2
    fosc_tick |=> !fosc_tick [*3])
    else $error("internal tick rate wrong");

  // The flag only falls through a software write to it
  flag_sticky_a: assert property (@(posedge mclk) disable iff (!resetn) // R20
    (s_r.flag && !(wr_go && avs_address == OFS_FLAG)) |=> s_r.flag)
    else $error("overflow flag dropped without a clear");

  // Capture copies the count as it stood at the event
  cap_copy_a: assert property (@(posedge mclk) disable iff (!resetn) // R23
    capture_event |=> (capture_value == $past(count_value)))
    else $error("capture did not copy the count");

  // Wake must be low from the cycle after the processor leaves sleep
  wake_sleep_a: assert property (@(posedge mclk) disable iff (!resetn) // R22
    !sleep |=> !wake)
    else $error("wake raised while awake");

  // A low byte read returns the byte as it stood when the request was taken
  sequence cnt_lo_rd_s;
    req_wait_s ##0 (avs_read && avs_address == OFS_CNT_LO);
  endsequence

  cnt_read_a: assert property (@(posedge mclk) disable iff (!resetn) // R12
    cnt_lo_rd_s |=> (avs_readdata == {24'h00, $past(count_value[7:0])}))
    else $error("count low byte read wrong");
endmodule : gtc_timer
`default_nettype wire

/* sim/gtc_pulse_src.sv */
// Pulse source model for the count pin or the crystal input
`timescale 1ns/1ps
`default_nettype none
module gtc_pulse_src (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Burst control
  input wire logic run,
  input wire logic [7:0] half_cycles,
  // Source level
  output logic pin
);
  logic [7:0] tick_r;

  // A started pulse is always finished, so the line rests low between bursts
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_r <= 8'h00;
      pin <= 1'h0;
    end
    else if (!(run || pin))
      tick_r <= 8'h00;
    else if (tick_r == half_cycles - 8'h01)
    begin
      tick_r <= 8'h00;
      pin <= ~pin;
    end
    else
      tick_r <= tick_r + 8'h01;
  end
endmodule : gtc_pulse_src
`default_nettype wire

/* sim/gated_16bit_timer_counter_tb_top.sv */
// Self-checking bench for the gated 16-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module gated_16bit_timer_counter_tb_top;
  import gtc_pkg::*;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rq;
  logic avs_waitrequest, count_input_pin, osc_input_pin, osc_run, irq, wake, compare_match;
  logic gate_pin = 1'h0;
  logic second_comparator_out = 1'h0;
  logic [1:0] port_bits_in = 2'h3;
  logic [1:0] port_dir_in = 2'h0;
  logic sleep = 1'h0;
  logic capture_event = 1'h0;
  logic special_event = 1'h0;
  logic [15:0] capture_compare_pair = 16'h0;
  logic [15:0] count_value, capture_value;
  logic src_run = 1'h0;
  logic [7:0] src_half = 8'h02;
  int miscompares = 0;
  int checks = 0;

  // 250 MHz clock
  always #2 mclk = ~mclk;

  gtc_timer uut (.mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .count_input_pin, .osc_input_pin,
    .gate_pin, .second_comparator_out, .port_bits_in, .port_dir_in, .sleep, .capture_event,
    .capture_compare_pair, .special_event, .count_value, .capture_value, .compare_match,
    .irq, .wake, .osc_run);
  // Pin source on demand; the crystal stand-in runs only while enabled
  gtc_pulse_src src (.mclk, .resetn, .run(src_run), .half_cycles(src_half),
    .pin(count_input_pin));
  gtc_pulse_src xtal (.mclk, .resetn, .run(osc_run), .half_cycles(8'h05),
    .pin(osc_input_pin));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Request stands until waitrequest is sampled low, data taken at that edge
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    do
      @(posedge mclk);
    while (avs_waitrequest !== 1'h0);
    rq = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'h1, d);
  endtask : wr

  task automatic rd(input string what, input logic [4:0] a, input logic [7:0] exp);
    bus(a, 1'h0, 8'h00);
    check(what, rq, {24'h0, exp});
  endtask : rd

  // Checks after a wait happen on the falling edge, once the design has settled
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt

  task automatic clr();
    wr(OFS_CTRL, 8'h00);
    wr(OFS_CNT_HI, 8'h00);
    wr(OFS_CNT_LO, 8'h00);
  endtask : clr

  // n full pulses on the count pin, first rise after a count write is unarmed
  task automatic pulses(input int n, input logic [7:0] h);
    @(posedge mclk);
    src_half <= h;
    src_run <= 1'h1;
    repeat (n) @(negedge count_input_pin);
    src_run <= 1'h0;
    wt(8);
  endtask : pulses

  task automatic t_regs();
    for (int i = 0; i < 7; i++)
      rd("reset", 5'(i * 4), 8'h00);
    avs_byteenable <= 4'h0;
    wr(OFS_CTRL, 8'h01);
    avs_byteenable <= 4'hF;
    rd("lane off", OFS_CTRL, 8'h00);
    wr(OFS_CNT_HI, 8'h12);
    wr(OFS_CNT_LO, 8'h34);
    rd("high", OFS_CNT_HI, 8'h12);
    rd("low", OFS_CNT_LO, 8'h34);
    wt(20);
    check("held", 32'(count_value), 32'h1234);
  endtask : t_regs

  // Internal clock over about 260 cycles gives 65 ticks before the divider
  task automatic t_pre();
    logic [15:0] c;
    int e;
    for (int k = 0; k < 4; k++)
    begin
      clr();
      wr(OFS_CTRL, 8'(8'h01 | (k << 4)));
      repeat (256) @(posedge mclk);
      wr(OFS_CTRL, 8'h00);
      wt(1);
      c = count_value;
      e = 65 >> k;
      check("divide", 32'(int'(c) >= e - 1 && int'(c) <= e + 1), 32'h1);
      wt(16);
      check("stopped", 32'(count_value), 32'(c));
    end
  endtask : t_pre

  task automatic t_ext();
    for (int i = 0; i < 2; i++)
    begin
      clr();
      wr(OFS_CTRL, 8'(8'h03 | (i << 2)));
      pulses(5, 8'(2 + 4 * i));
      check("edges", 32'(count_value), 32'h4);
    end
    // Leave residue in the divider so that only a cleared one gives zero
    wr(OFS_CTRL, 8'h33);
    pulses(6, 8'h02);
    wr(OFS_CNT_LO, 8'h00);
    pulses(8, 8'h02);
    check("div residue", 32'(count_value), 32'h0);
    pulses(2, 8'h02);
    check("div eight", 32'(count_value), 32'h1);
  endtask : t_ext

  // Bits: count expected, source select, pin, comparator, control byte
  task automatic t_gate();
    logic [11:0] g [7] = '{12'hAC1, 12'h1C1, 12'h841, 12'h6C1, 12'hDC1, 12'hC41, 12'h801};
    for (int i = 0; i < 7; i++)
    begin
      clr();
      wr(OFS_CMP_CTRL, {6'h0, g[i][10], 1'h1});
      gate_pin <= g[i][9];
      second_comparator_out <= g[i][8];
      wr(OFS_CTRL, g[i][7:0]);
      wt(40);
      check("gate", 32'(count_value != 16'h0), 32'(g[i][11]));
    end
  endtask : t_gate

  task automatic t_ovf();
    clr();
    wr(OFS_FLAG, 8'h00);
    wr(OFS_ENABLE, 8'h01);
    wr(OFS_IRQ_CTRL, 8'h40);
    wr(OFS_CNT_HI, 8'hFF);
    wr(OFS_CNT_LO, 8'hFE);
    wr(OFS_CTRL, 8'h01);
    wt(12);
    wr(OFS_CTRL, 8'h00);
    check("rollover", 32'(count_value[15:4]), 32'h0);
    rd("flag", OFS_FLAG, 8'h01);
    check("irq no gie", 32'(irq), 32'h0);
    wr(OFS_IRQ_CTRL, 8'hC0);
    wt(2);
    check("irq", 32'(irq), 32'h1);
    wr(OFS_ENABLE, 8'h00);
    wt(2);
    check("irq masked", 32'(irq), 32'h0);
    rd("sticky", OFS_FLAG, 8'h01);
    wr(OFS_FLAG, 8'h00);
    rd("cleared", OFS_FLAG, 8'h00);
    wr(OFS_CNT_HI, 8'h12);
    // Event lands on the edge where the write takes effect
    fork
      wr(OFS_CNT_LO, 8'h55);
      begin
        repeat (2) @(posedge mclk);
        special_event <= 1'h1;
        @(posedge mclk);
        special_event <= 1'h0;
      end
    join
    wt(1);
    check("write wins", 32'(count_value), 32'h1255);
    @(posedge mclk);
    special_event <= 1'h1;
    @(posedge mclk);
    special_event <= 1'h0;
    wt(1);
    check("event clear", 32'(count_value), 32'h0);
    rd("no flag", OFS_FLAG, 8'h00);
  endtask : t_ovf

  task automatic t_sleep();
    clr();
    wr(OFS_CNT_HI, 8'hFF);
    wr(OFS_IRQ_CTRL, 8'h40);
    wr(OFS_ENABLE, 8'h01);
    sleep <= 1'h1;
    wr(OFS_CTRL, 8'h03);
    pulses(3, 8'h02);
    check("sync asleep", 32'(count_value), 32'hFF00);
    wr(OFS_CNT_LO, 8'hFF);
    wr(OFS_CTRL, 8'h07);
    pulses(3, 8'h02);
    check("async asleep", 32'(count_value), 32'h0001);
    check("wake", 32'(wake), 32'h1);
    @(posedge mclk);
    sleep <= 1'h0;
    wt(2);
    check("awake", 32'(wake), 32'h0);
  endtask : t_sleep

  task automatic t_osc();
    clr();
    rd("port", OFS_PORT, 8'h03);
    wr(OFS_CTRL, 8'h08);
    rd("port osc", OFS_PORT, 8'h0C);
    check("osc run", 32'(osc_run), 32'h1);
    wt(20);
    wr(OFS_CTRL, 8'h0F);
    wt(200);
    wr(OFS_CTRL, 8'h00);
    check("osc count", 32'(count_value > 16'h10), 32'h1);
  endtask : t_osc

  task automatic t_ccp();
    clr();
    wr(OFS_CNT_HI, 8'h12);
    wr(OFS_CNT_LO, 8'h34);
    capture_compare_pair <= 16'h1234;
    wt(3);
    check("match", 32'(compare_match), 32'h1);
    @(posedge mclk);
    capture_compare_pair <= 16'h1235;
    capture_event <= 1'h1;
    @(posedge mclk);
    capture_event <= 1'h0;
    wt(2);
    check("no match", 32'(compare_match), 32'h0);
    check("capture", 32'(capture_value), 32'h1234);
  endtask : t_ccp

  task automatic finish_test();
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Hang guard, far beyond the few thousand cycles the run needs
  initial
  begin
    #200000;
    miscompares++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1'h1;
    t_regs();
    t_pre();
    t_ext();
    t_gate();
    t_ovf();
    t_sleep();
    t_osc();
    t_ccp();
    finish_test();
  end
endmodule : gated_16bit_timer_counter_tb_top
`default_nettype wire
